// file: design/adc_auto_sequencer.v
// Auto-mode converter sequencer with APB register file and capture interrupts
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_regs.vh"
module adc_auto_sequencer #(
	parameter DATA_W = 15,
	parameter LEN_W  = 10
) (
	input  wire              clock_i,
	input  wire              rst_i,
	input  wire              psel_i,
	input  wire              penable_i,
	input  wire              pwrite_i,
	input  wire [11:0]       paddr_i,
	input  wire [31:0]       pwdata_i,
	output reg  [31:0]       prdata_o,
	output reg               pready_o,
	output reg               pslverr_o,
	input  wire [DATA_W-1:0] adc_data_i,
	output reg               adc_run_o,
	output reg  [1:0]        adc_chan_o,
	output reg  [3:0]        ain_p_o,
	output reg  [3:0]        ain_n_o,
	output reg  [7:0]        portb_p_o,
	output reg  [7:0]        portb_n_o,
	output wire              adc_clk_en_o,
	output reg  [DATA_W-1:0] left_result_o,
	output reg  [DATA_W-1:0] right_result_o,
	output reg  [DATA_W-1:0] misc_result_o,
	output reg               result_valid_flag_o,
	output reg               irq_o
);
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_SET  = 3'b010;
	localparam [2:0] ST_CAPT = 3'b100;
	// Power-down comes up set so the sequencer idles until software wakes it
	localparam [7:0] RST_POWER_BYTE = `RST_POWER;

	// Software-visible configuration
	reg [7:0] sel_misc;
	reg [7:0] sel_left;
	reg [7:0] sel_right;
	reg [7:0] misc_cap_lo;
	reg [7:0] lr_cap_lo;
	reg [7:0] len_hi;
	reg [7:0] chan_ctrl;
	reg [2:0] clk_div;
	reg       power_down;
	reg [2:0] int_status;
	reg [2:0] int_mask;

	// Sequencer state
	reg [2:0]       state;
	reg [2:0]       state_idx;
	reg [LEN_W-1:0] cycle_cnt;
	reg [2:0]       next_state;
	reg [2:0]       next_idx;

	wire [LEN_W-1:0] misc_capture_length;
	wire [LEN_W-1:0] lr_capture_length;
	wire [3:0]       set_length;
	wire [2:0]       max_idx;
	wire [2:0]       eff_en;
	wire             seq_enable;
	wire [1:0]       cur_ch;
	wire [7:0]       cur_sel;
	wire             last_idx;
	reg  [LEN_W-1:0] state_len;
	wire             state_done;
	wire             capt_end;
	wire [2:0]       capt_event;

	// APB decode
	wire       access;
	wire       wr_strobe;
	wire       rd_take;
	wire [7:0] reg_idx;
	wire       addr_ok;
	wire [7:0] wbyte;

	function [1:0] slot_chan;
		input [2:0] en;
		input [1:0] slot;
		reg   [1:0] k;
		integer     i;
		begin
			slot_chan = `CH_NONE;
			k = 2'd0;
			for (i = 0; i < 3; i = i + 1) begin
				if (en[i]) begin
					if (k == slot && slot_chan == `CH_NONE)
						slot_chan = i[1:0];
					k = k + 2'd1;
				end
			end
		end
	endfunction

	// Codes 1..8 pick port B bits 0..7; anything else selects no port B pin
	function [7:0] portb_bit;
		input [3:0] code;
		begin
			if (code >= 4'h1 && code <= 4'h8)
				portb_bit = 8'h01 << (code - 4'h1);
			else
				portb_bit = 8'h00;
		end
	endfunction

	function [7:0] sel_of;
		input [1:0] ch;
		input [7:0] l;
		input [7:0] r;
		input [7:0] m;
		begin
			case (ch)
				`CH_LEFT:  sel_of = l;
				`CH_RIGHT: sel_of = r;
				`CH_MISC:  sel_of = m;
				default:   sel_of = 8'h00;
			endcase
		end
	endfunction

	function mapped;
		input [7:0] idx;
		begin
			case (idx)
				`IDX_INT_STATUS, `IDX_INT_MASK, `IDX_SEL_MISC, `IDX_SEL_LEFT,
				`IDX_SEL_RIGHT, `IDX_MISC_CAP_LO, `IDX_LR_CAP_LO, `IDX_LEN_HI,
				`IDX_CHAN_CTRL, `IDX_CLK_DIV, `IDX_RESULT_LO, `IDX_RESULT_HI,
				`IDX_POWER: mapped = 1'b1;
				default:    mapped = 1'b0;
			endcase
		end
	endfunction

	assign misc_capture_length = {len_hi[`LEN_MISC_MSB:`LEN_MISC_LSB], misc_cap_lo};
	assign lr_capture_length   = {len_hi[`LEN_LR_MSB:`LEN_LR_LSB], lr_cap_lo};
	assign set_length          = len_hi[`LEN_SET_MSB:0];
	assign max_idx             = chan_ctrl[`CTRL_MAX_MSB:`CTRL_MAX_LSB];
	// Right is masked off unless left is on, whatever software wrote
	assign eff_en     = {chan_ctrl[2], chan_ctrl[1] & chan_ctrl[0], chan_ctrl[0]};
	assign seq_enable = ~power_down & (|eff_en);
	// Even index is a Set state, odd the Capture state of the same slot
	assign cur_ch     = slot_chan(eff_en, state_idx[2:1]);
	// One decode of the slot's select byte feeds both nibbles and both port B maps
	assign cur_sel    = sel_of(cur_ch, sel_left, sel_right, sel_misc);
	// The maximum index counts the states of a period, so the last one is max-1
	assign last_idx   = ({1'b0, state_idx} + 4'd1) >= {1'b0, max_idx};

	always @* begin
		state_len = {{(LEN_W-4){1'b0}}, set_length};
		if (state == ST_CAPT) begin
			if (cur_ch == `CH_MISC)
				state_len = misc_capture_length;
			else
				state_len = lr_capture_length;
		end
	end

	// A zero length still takes one cycle so the sequence cannot stall
	assign state_done = ({1'b0, cycle_cnt} + {{LEN_W{1'b0}}, 1'b1}) >= {1'b0, state_len};
	assign capt_end   = (state == ST_CAPT) && state_done && seq_enable && (cur_ch != `CH_NONE);
	assign capt_event = capt_end ? (3'b001 << cur_ch) : 3'b000;

	always @* begin
		next_state = state;
		next_idx   = state_idx;
		case (state)
			ST_IDLE: begin
				next_idx = 3'd0;
				if (seq_enable)
					next_state = ST_SET;
			end
			ST_SET, ST_CAPT: begin
				if (!seq_enable) begin
					next_state = ST_IDLE;
					next_idx   = 3'd0;
				end else if (state_done) begin
					next_idx   = last_idx ? 3'd0 : state_idx + 3'd1;
					next_state = next_idx[0] ? ST_CAPT : ST_SET;
				end
			end
			default: begin
				next_state = ST_IDLE;
				next_idx   = 3'd0;
			end
		endcase
	end

	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			state     <= ST_IDLE;
			state_idx <= 3'd0;
			cycle_cnt <= {LEN_W{1'b0}};
		end else begin
			state     <= next_state;
			state_idx <= next_idx;
			if (state_done || next_state != state || state == ST_IDLE)
				cycle_cnt <= {LEN_W{1'b0}};
			else
				cycle_cnt <= cycle_cnt + {{(LEN_W-1){1'b0}}, 1'b1};
		end
	end

	// Run strobe, channel and input selects toward the converter core
	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			adc_run_o  <= 1'b0;
			adc_chan_o <= `CH_NONE;
			ain_p_o    <= 4'h0;
			ain_n_o    <= 4'h0;
			portb_p_o  <= 8'h00;
			portb_n_o  <= 8'h00;
		end else begin
			adc_run_o <= seq_enable && (next_state == ST_CAPT) &&
				(state != ST_CAPT || next_idx != state_idx) &&
				(slot_chan(eff_en, next_idx[2:1]) != `CH_NONE);
			adc_chan_o <= (state == ST_IDLE) ? `CH_NONE : cur_ch;
			// Selects follow the current slot one cycle late; the Set state covers the lag
			ain_p_o   <= cur_sel[7:4];
			ain_n_o   <= cur_sel[3:0];
			portb_p_o <= portb_bit(cur_sel[7:4]);
			portb_n_o <= portb_bit(cur_sel[3:0]);
		end
	end

	// Results hold until their own channel captures again
	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			left_result_o       <= {DATA_W{1'b0}};
			right_result_o      <= {DATA_W{1'b0}};
			misc_result_o       <= {DATA_W{1'b0}};
			result_valid_flag_o <= 1'b0;
		end else begin
			if (capt_event[0])
				left_result_o <= adc_data_i;
			if (capt_event[1])
				right_result_o <= adc_data_i;
			if (capt_event[2])
				misc_result_o <= adc_data_i;
			// Cleared by hardware when the next conversion is launched
			if (capt_end)
				result_valid_flag_o <= 1'b1;
			else if (adc_run_o)
				result_valid_flag_o <= 1'b0;
		end
	end

	assign access    = psel_i & penable_i;
	assign wr_strobe = access & pready_o & pwrite_i;
	assign rd_take   = access & ~pready_o;
	assign reg_idx   = paddr_i[9:2];
	assign addr_ok   = (paddr_i[11:10] == 2'b00) && (paddr_i[1:0] == 2'b00) && mapped(reg_idx);
	assign wbyte     = pwdata_i[7:0];

	// One wait state: pready rises on the second access cycle with data already registered
	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h00000000;
		end else begin
			pready_o  <= rd_take;
			pslverr_o <= rd_take & ~addr_ok;
			if (rd_take && !pwrite_i) begin
				case (reg_idx)
					`IDX_INT_STATUS:  prdata_o <= {29'h0, int_status};
					`IDX_INT_MASK:    prdata_o <= {29'h0, int_mask};
					`IDX_SEL_MISC:    prdata_o <= {24'h0, sel_misc};
					`IDX_SEL_LEFT:    prdata_o <= {24'h0, sel_left};
					`IDX_SEL_RIGHT:   prdata_o <= {24'h0, sel_right};
					`IDX_MISC_CAP_LO: prdata_o <= {24'h0, misc_cap_lo};
					`IDX_LR_CAP_LO:   prdata_o <= {24'h0, lr_cap_lo};
					`IDX_LEN_HI:      prdata_o <= {24'h0, len_hi};
					`IDX_CHAN_CTRL:   prdata_o <= {24'h0, chan_ctrl};
					`IDX_CLK_DIV:     prdata_o <= {29'h0, clk_div};
					`IDX_RESULT_LO:   prdata_o <= {24'h0, misc_result_o[7:0]};
					`IDX_RESULT_HI:   prdata_o <= {24'h0, result_valid_flag_o,
						misc_result_o[14:8]};
					`IDX_POWER:       prdata_o <= {26'h0, power_down, 5'h00};
					default:          prdata_o <= 32'h00000000;
				endcase
			end
		end
	end

	// Configuration writes; result registers are read-only
	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			sel_misc    <= `RST_BYTE;
			sel_left    <= `RST_BYTE;
			sel_right   <= `RST_BYTE;
			misc_cap_lo <= `RST_BYTE;
			lr_cap_lo   <= `RST_BYTE;
			len_hi      <= `RST_BYTE;
			chan_ctrl   <= `RST_BYTE;
			clk_div     <= 3'h0;
			power_down  <= RST_POWER_BYTE[`POWER_DOWN_BIT];
			int_mask    <= 3'h0;
		end else if (wr_strobe) begin
			case (reg_idx)
				`IDX_SEL_MISC:    sel_misc    <= wbyte;
				`IDX_SEL_LEFT:    sel_left    <= wbyte;
				`IDX_SEL_RIGHT:   sel_right   <= wbyte;
				`IDX_MISC_CAP_LO: misc_cap_lo <= wbyte;
				`IDX_LR_CAP_LO:   lr_cap_lo   <= wbyte;
				`IDX_LEN_HI:      len_hi      <= wbyte;
				`IDX_CHAN_CTRL:   chan_ctrl   <= wbyte & 8'h77;
				`IDX_CLK_DIV:     clk_div     <= wbyte[2:0];
				`IDX_POWER:       power_down  <= wbyte[`POWER_DOWN_BIT];
				`IDX_INT_MASK:    int_mask    <= wbyte[2:0];
				default:          power_down  <= power_down;
			endcase
		end
	end

	// Sticky capture events; a new event wins over a write-one clear
	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			int_status <= 3'h0;
			irq_o      <= 1'b0;
		end else begin
			if (wr_strobe && reg_idx == `IDX_INT_STATUS)
				int_status <= (int_status & ~wbyte[2:0]) | capt_event;
			else
				int_status <= int_status | capt_event;
			irq_o <= |(int_status & int_mask);
		end
	end

	adc_clk_divider #(
		.DIV_W (3)
	) adc_clk_divider_inst (
		.clock_i  (clock_i),
		.rst_i    (rst_i),
		.div_i    (clk_div),
		.clk_en_o (adc_clk_en_o)
	);
endmodule
`default_nettype wire

// file: design/adc_seq_regs.vh
// Register indices, field positions, reset values and channel codes of the auto-mode sequencer
`ifndef ADC_SEQ_REGS_VH
`define ADC_SEQ_REGS_VH

// Register indices; byte address is four times the index
`define IDX_INT_STATUS   8'he0
`define IDX_INT_MASK     8'he1
`define IDX_SEL_MISC     8'he8
`define IDX_SEL_LEFT     8'he9
`define IDX_SEL_RIGHT    8'hea
`define IDX_MISC_CAP_LO  8'hef
`define IDX_LR_CAP_LO    8'hf0
`define IDX_LEN_HI       8'hf1
`define IDX_CHAN_CTRL    8'hf2
`define IDX_CLK_DIV      8'hf4
`define IDX_RESULT_LO    8'hf7
`define IDX_RESULT_HI    8'hf8
`define IDX_POWER        8'hfc

// Field positions
`define LEN_SET_MSB      3
`define LEN_LR_MSB       5
`define LEN_LR_LSB       4
`define LEN_MISC_MSB     7
`define LEN_MISC_LSB     6
`define CTRL_EN_MSB      2
`define CTRL_MAX_MSB     6
`define CTRL_MAX_LSB     4
`define POWER_DOWN_BIT   5
`define RESULT_VALID_BIT 7

// Reset values
`define RST_BYTE         8'h00
`define RST_POWER        8'h20

// Channel codes on the sequencer side
`define CH_LEFT          2'h0
`define CH_RIGHT         2'h1
`define CH_MISC          2'h2
`define CH_NONE          2'h3

`endif

// file: design/adc_clk_divider.v
// Converter clock enable: one pulse every divider+1 crystal cycles
`timescale 1ns/1ps
`default_nettype none
module adc_clk_divider #(
	parameter DIV_W = 3
) (
	input  wire             clock_i,
	input  wire             rst_i,
	input  wire [DIV_W-1:0] div_i,
	output reg              clk_en_o
);
	reg [DIV_W-1:0] count;

	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			count    <= {DIV_W{1'b0}};
			clk_en_o <= 1'b0;
		end else if (count >= div_i) begin
			count    <= {DIV_W{1'b0}};
			clk_en_o <= 1'b1;
		end else begin
			count    <= count + {{(DIV_W-1){1'b0}}, 1'b1};
			clk_en_o <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// file: sim/adc_seq_props.sv
// Port checker for the auto-mode sequencer
`timescale 1ns/1ps
`default_nettype none
module adc_seq_props #(
	parameter DATA_W = 15
) (
	input wire              clock_i,
	input wire              rst_i,
	input wire              psel_i,
	input wire              penable_i,
	input wire              pready_o,
	input wire              pslverr_o,
	input wire [DATA_W-1:0] adc_data_i,
	input wire              adc_run_o,
	input wire [1:0]        adc_chan_o,
	input wire [DATA_W-1:0] left_result_o,
	input wire [DATA_W-1:0] misc_result_o,
	input wire              result_valid_flag_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	a_run_spacing: assert property (adc_run_o |=> !adc_run_o)
		else $error("run pulses too close");
	a_run_has_chan: assert property (adc_run_o |-> adc_chan_o != 2'h3)
		else $error("run pulse with no channel");
	a_left_latch: assert property ($changed(left_result_o) |-> left_result_o == $past(adc_data_i))
		else $error("left result not the converter word");
	a_misc_latch: assert property ($changed(misc_result_o) |-> misc_result_o == $past(adc_data_i))
		else $error("misc result not the converter word");
	a_latch_valid: assert property ($changed(misc_result_o) |-> ##[0:1] result_valid_flag_o)
		else $error("valid flag missing after capture");
	a_valid_clear: assert property (adc_run_o |-> ##[1:2] !result_valid_flag_o)
		else $error("valid flag not cleared");
	a_ready_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
		else $error("ready late");
	a_ready_pulse: assert property (pready_o |=> !pready_o)
		else $error("ready held");
	a_ready_needs_req: assert property (pready_o |-> psel_i && penable_i)
		else $error("ready without request");
	a_err_ready: assert property (pslverr_o |-> pready_o)
		else $error("error without ready");
	c_right_run: cover property (adc_run_o && adc_chan_o == 2'h1);
	c_misc_run: cover property (adc_run_o && adc_chan_o == 2'h2);
	c_slave_err: cover property (pslverr_o);
endmodule
bind adc_auto_sequencer adc_seq_props #(.DATA_W(DATA_W)) adc_seq_props_inst (.clock_i(clock_i),
	.rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .pready_o(pready_o),
	.pslverr_o(pslverr_o), .adc_data_i(adc_data_i), .adc_run_o(adc_run_o),
	.adc_chan_o(adc_chan_o), .left_result_o(left_result_o), .misc_result_o(misc_result_o),
	.result_valid_flag_o(result_valid_flag_o));
`default_nettype wire

// file: sim/adc_conv_model.sv
// Behavioural converter core answering each run pulse with a new word
`timescale 1ns/1ps
`default_nettype none
module adc_conv_model (
	input  wire        clock_i,
	input  wire        rst_i,
	input  wire        run_i,
	input  wire [1:0]  chan_i,
	output wire [14:0] data_o
);
	reg [14:0] word;
	reg [14:0] last_misc;
	reg [7:0]  count;
	reg [1:0]  busy;
	// The word is in flux while converting, so show its inverse then
	assign data_o = (busy != 2'h0) ? ~word : word;
	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			word <= 15'h0000;
			last_misc <= 15'h0000;
			count <= 8'h00;
			busy <= 2'h0;
		end else if (run_i) begin
			count <= count + 8'h01;
			word <= {chan_i, 5'h0a, count} ^ 15'h2c00;
			busy <= 2'h2;
			if (chan_i == 2'h2)
				last_misc <= {chan_i, 5'h0a, count} ^ 15'h2c00;
		end else if (busy != 2'h0) begin
			busy <= busy - 2'h1;
		end
	end
endmodule
`default_nettype wire

// file: sim/adc_auto_mode_sequencer_tb.sv
// Register-level bench for the auto-mode sequencer
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_regs.vh"
module adc_auto_mode_sequencer_tb;
	logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [14:0] adc_data, left_res, right_res, misc_res, exp_misc;
	logic [7:0]  portb_p, portb_n;
	logic [3:0]  ain_p, ain_n;
	logic [1:0]  adc_chan;
	logic        pready, pslverr, adc_run, clk_en, valid, irq;
	int          fail_count = 0, checked = 0, cyc = 0;
	adc_auto_sequencer adc_auto_sequencer_inst (.clock_i(clk), .rst_i(rst), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .adc_data_i(adc_data),
		.adc_run_o(adc_run), .adc_chan_o(adc_chan), .ain_p_o(ain_p), .ain_n_o(ain_n),
		.portb_p_o(portb_p), .portb_n_o(portb_n), .adc_clk_en_o(clk_en),
		.left_result_o(left_res), .right_result_o(right_res), .misc_result_o(misc_res),
		.result_valid_flag_o(valid), .irq_o(irq));
	adc_conv_model adc_conv_model_inst (.clock_i(clk), .rst_i(rst), .run_i(adc_run),
		.chan_i(adc_chan), .data_o(adc_data));
	initial begin
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			print_verdict();
		end
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= {24'h0, wd};
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	// Cycles from one run pulse of channel ch to the next, and run pulses seen after the first, the closing one included
	task automatic period(input logic [1:0] ch, output int len, output int runs);
		len = 0;
		runs = 0;
		while (!(adc_run === 1'b1 && adc_chan === ch)) @(posedge clk);
		do begin
			@(posedge clk);
			len++;
			if (adc_run === 1'b1)
				runs++;
			if (adc_run === 1'b1 && adc_chan === 2'h0)
				chk("select", {4'h1, 4'h2, 8'h01, 8'h02}, {ain_p, ain_n, portb_p, portb_n});
		end while (!(adc_run === 1'b1 && adc_chan === ch));
	endtask
	task automatic print_verdict();
		$display("Checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		int len, runs;
		logic [14:0] held;
		logic [2:0] en [5] = '{3'h7, 3'h5, 3'h3, 3'h1, 3'h4};
		logic [2:0] mx [5] = '{3'h6, 3'h4, 3'h4, 3'h2, 3'h2};
		int nlr [5] = '{2, 1, 2, 1, 0};
		int nm [5] = '{1, 1, 0, 0, 1};
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("idle channel", 32'h3, {30'h0, adc_chan});
		apb(1'b0, `IDX_POWER, 8'h00);
		chk("power reset", 32'h20, rd);
		apb(1'b0, 8'h00, 8'h00);
		chk("unmapped", 32'h1, {rd[30:0], err});
		apb(1'b1, `IDX_CLK_DIV, 8'h05);
		for (int i = 0; i < 3; i++) begin
			len = 0;
			do begin
				@(posedge clk);
				len++;
			end while (clk_en !== 1'b1);
		end
		chk("clock divide", 32'd6, len);
		apb(1'b1, `IDX_SEL_LEFT, 8'h12);
		apb(1'b1, `IDX_LR_CAP_LO, 8'h0a);
		apb(1'b1, `IDX_MISC_CAP_LO, 8'h04);
		apb(1'b1, `IDX_LEN_HI, 8'h43);
		apb(1'b1, `IDX_INT_MASK, 8'h01);
		for (int m = 0; m < 5; m++) begin
			apb(1'b1, `IDX_POWER, 8'h20);
			apb(1'b1, `IDX_CHAN_CTRL, {1'b0, mx[m], 1'b0, en[m]});
			apb(1'b1, `IDX_POWER, 8'h00);
			held = left_res;
			period((nlr[m] > 0) ? 2'h0 : 2'h2, len, runs);
			chk("period", (nlr[m] + nm[m]) * 3 + nlr[m] * 10 + nm[m] * 260, len);
			chk("runs", nlr[m] + nm[m], runs);
			if (nlr[m] > 0)
				chk("left word", 32'h26, {25'h0, left_res[14:8]});
			if (nlr[m] == 2)
				chk("right word", 32'h06, {25'h0, right_res[14:8]});
			if (nlr[m] == 0)
				chk("left held", {17'h0, held}, {17'h0, left_res});
		end
		repeat (3) @(posedge clk);
		while (valid !== 1'b1) @(posedge clk);
		exp_misc = adc_conv_model_inst.last_misc;
		apb(1'b1, `IDX_POWER, 8'h20);
		apb(1'b1, `IDX_RESULT_LO, 8'hff);
		apb(1'b0, `IDX_RESULT_LO, 8'h00);
		held[7:0] = rd[7:0];
		apb(1'b0, `IDX_RESULT_HI, 8'h00);
		chk("misc result", {17'h0, exp_misc}, {17'h0, rd[6:0], held[7:0]});
		apb(1'b0, `IDX_INT_STATUS, 8'h00);
		chk("status", 32'h7, rd);
		chk("irq raised", 32'h1, {31'h0, irq});
		apb(1'b1, `IDX_INT_MASK, 8'h00);
		apb(1'b0, `IDX_INT_STATUS, 8'h00);
		chk("irq masked", 32'h0, {31'h0, irq});
		apb(1'b1, `IDX_INT_STATUS, 8'h07);
		apb(1'b0, `IDX_INT_STATUS, 8'h00);
		chk("status cleared", 32'h0, rd);
		apb(1'b1, `IDX_CHAN_CTRL, 8'h22);
		apb(1'b1, `IDX_POWER, 8'h00);
		runs = 0;
		repeat (100) begin
			@(posedge clk);
			if (adc_run !== 1'b0)
				runs++;
		end
		chk("right alone", 32'h0, runs);
		print_verdict();
	end
endmodule
`default_nettype wire
